// File: logic/ttc_pkg.sv
// Purpose: Shared constants for the timer two control block
// Assumes: 8-bit special function register bus on the system clock
// Notes:   Offsets are bus addresses; bit positions index the control byte
package ttc_pkg;

    // Register addresses on the special function register bus
    localparam logic [7:0] CTRL_ADDR   = 8'hC8;
    localparam logic [7:0] RLD_LO_ADDR = 8'hCA;
    localparam logic [7:0] RLD_HI_ADDR = 8'hCB;
    localparam logic [7:0] CNT_LO_ADDR = 8'hCC;
    localparam logic [7:0] CNT_HI_ADDR = 8'hCD;

    // Control byte field positions
    localparam int HF_BIT     = 7;
    localparam int LF_BIT     = 6;
    localparam int LEN_BIT    = 5;
    localparam int CEN_BIT    = 4;
    localparam int SPLIT_BIT  = 3;
    localparam int RUN_BIT    = 2;
    localparam int UNUSED_BIT = 1;
    localparam int XCLK_BIT   = 0;

    // Reset values and masks
    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    localparam logic [7:0]  CTRL_WR_MASK = 8'hFD;
    localparam logic [7:0]  BYTE_RESET   = 8'h00;
    localparam logic [7:0]  BYTE_MAX     = 8'hFF;
    localparam logic [7:0]  BYTE_ONE     = 8'h01;
    localparam logic [7:0]  UNMAPPED_RD  = 8'h00;

    // Prescaler ratios
    localparam int SYS_DIV = 12;
    localparam int EXT_DIV = 8;

    // Counter structure selected by the split bit
    typedef enum logic {
        TTC_MODE_WORD  = 1'b0,
        TTC_MODE_SPLIT = 1'b1
    } ttc_mode_t;

endpackage : ttc_pkg

// File: logic/ttc_sync_edge.sv
// Purpose: Two-flop synchroniser with rise and fall strobes
// Assumes: Input toggles slower than half the system clock
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module ttc_sync_edge (
    input  wire logic clock_i,
    input  wire logic rst_b_i,
    input  wire logic async_i,
    output logic      rise_o,
    output logic      fall_o
);

    logic meta_r;
    logic sync_r;
    logic prev_r;

    // Two stages, then one more for edge history
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // One-cycle strobes from the settled stages only
    assign rise_o = sync_r & ~prev_r;
    assign fall_o = ~sync_r & prev_r;

endmodule : ttc_sync_edge

// File: logic/ttc_tick_gen.sv
// Purpose: Prescaler ticks: system clock over SYS_DIV, external over EXT_DIV
// Assumes: ext_rise_i is already a synchronised one-cycle strobe
// Notes:   Ticks are registered one-cycle pulses
`timescale 1ns/1ps
module ttc_tick_gen #(
    parameter int SYS_DIV = ttc_pkg::SYS_DIV,
    parameter int EXT_DIV = ttc_pkg::EXT_DIV
) (
    input  wire logic clock_i,
    input  wire logic rst_b_i,
    input  wire logic ext_rise_i,
    output logic      sys_tick_o,
    output logic      ext_tick_o
);

    localparam int SW = (SYS_DIV > 2) ? $clog2(SYS_DIV) : 1;
    localparam int EW = (EXT_DIV > 2) ? $clog2(EXT_DIV) : 1;
    localparam logic [SW-1:0] SYS_LAST = SW'(SYS_DIV - 1);
    localparam logic [EW-1:0] EXT_LAST = EW'(EXT_DIV - 1);

    // Ratios below two cannot form a divider
    if (SYS_DIV < 2 || EXT_DIV < 2) begin : g_bad_div
        $error("ttc_tick_gen: divide ratios must be at least two");
    end

    logic [SW-1:0] sys_cnt_r;
    logic [EW-1:0] ext_cnt_r;

    // System clock divider, free running
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sys_cnt_r  <= '0;
            sys_tick_o <= 1'b0;
        end else begin
            sys_tick_o <= (sys_cnt_r == SYS_LAST);
            sys_cnt_r  <= (sys_cnt_r == SYS_LAST) ? '0 : sys_cnt_r + SW'(1);
        end
    end

    // External divider counts synchronised rising edges
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ext_cnt_r  <= '0;
            ext_tick_o <= 1'b0;
        end else begin
            ext_tick_o <= ext_rise_i & (ext_cnt_r == EXT_LAST);
            if (ext_rise_i) begin
                ext_cnt_r <= (ext_cnt_r == EXT_LAST) ? '0 : ext_cnt_r + EW'(1);
            end
        end
    end

endmodule : ttc_tick_gen

// File: logic/ttc_timer2_control.sv
// Purpose: Timer two control, count, reload and capture logic
// Assumes: Core reaches it over the special function register bus
// Notes:   Clock select and interrupt enable bits arrive from core registers
`timescale 1ns/1ps
module ttc_timer2_control #(
    parameter int SYS_DIV = ttc_pkg::SYS_DIV,
    parameter int EXT_DIV = ttc_pkg::EXT_DIV
) (
    input  wire logic       clock_i,
    input  wire logic       rst_b_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic [7:0] sfr_wdata_i,
    input  wire logic       sfr_bit_wr_i,
    input  wire logic [2:0] sfr_bit_sel_i,
    input  wire logic       sfr_bit_val_i,
    input  wire logic       sfr_rd_i,
    input  wire logic       timer_irq_enable_i,
    input  wire logic       high_byte_system_clock_select_i,
    input  wire logic       low_byte_system_clock_select_i,
    input  wire logic       ext_osc_i,
    input  wire logic       low_freq_oscillator_i,
    output logic [7:0]      sfr_rdata_o,
    output logic            irq_o
);

    // The prescaler needs a ratio of two or more to form a divider
    if (SYS_DIV < 2 || EXT_DIV < 2) begin : g_bad_ratio
        $error("ttc_timer2_control: divide ratios must be at least two");
    end

    // Storage
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [7:0] cnt_lo_r;
    logic [7:0] cnt_lo_nxt;
    logic [7:0] cnt_hi_r;
    logic [7:0] cnt_hi_nxt;
    logic [7:0] rld_lo_r;
    logic [7:0] rld_hi_r;
    logic [7:0] rdata_r;
    logic       irq_r;

    // Decode and event wires
    logic       wr_ctrl;
    logic [7:0] ctrl_wr_val;
    logic       wr_cnt_lo;
    logic       wr_cnt_hi;
    logic       wr_rld_lo;
    logic       wr_rld_hi;
    logic       ext_rise;
    logic       slow_fall;
    logic       sys_tick;
    logic       ext_tick;
    logic       alt_tick;
    logic       lo_tick;
    logic       hi_tick;
    logic       lo_step;
    logic       hi_step;
    logic       lo_wrap;
    logic       hi_wrap;
    logic       cap_strobe;
    ttc_pkg::ttc_mode_t mode;

    // Field views of the control byte
    logic run;
    logic cap_en;
    logic len;
    logic xclk;

    assign run    = ctrl_r[ttc_pkg::RUN_BIT];
    assign cap_en = ctrl_r[ttc_pkg::CEN_BIT];
    assign len    = ctrl_r[ttc_pkg::LEN_BIT];
    assign xclk   = ctrl_r[ttc_pkg::XCLK_BIT];
    assign mode   = ttc_pkg::ttc_mode_t'(ctrl_r[ttc_pkg::SPLIT_BIT]);

    // External oscillator edge, resynchronised to the system clock
    // Synchronised external source
    ttc_sync_edge u_ext_sync (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .async_i (ext_osc_i),
        .rise_o  (ext_rise),
        .fall_o  ()
    );

    // Oscillator falling edge becomes a single-cycle strobe
    // Synchronise and detect edge
    ttc_sync_edge u_slow_sync (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .async_i (low_freq_oscillator_i),
        .rise_o  (),
        .fall_o  (slow_fall)
    );

    // Prescaled ticks for the alternate clock source
    ttc_tick_gen #(
        .SYS_DIV (SYS_DIV),
        .EXT_DIV (EXT_DIV)
    ) u_ticks (
        .clock_i    (clock_i),
        .rst_b_i    (rst_b_i),
        .ext_rise_i (ext_rise),
        .sys_tick_o (sys_tick),
        .ext_tick_o (ext_tick)
    );

    // Alternate source shared by both bytes
    // System or external divider picked by xclk
    assign alt_tick = xclk ? ext_tick : sys_tick;

    // Per-byte source: system clock every cycle, else alternate
    // Per-byte source choice
    assign lo_tick = low_byte_system_clock_select_i ? 1'b1 : alt_tick;
    assign hi_tick = high_byte_system_clock_select_i ? 1'b1 : alt_tick;

    // Byte address decode; bit writes only reach the control byte
    // Bit writes aimed at any other address fall through and are dropped
    always_comb begin
        wr_ctrl   = 1'b0;
        wr_cnt_lo = 1'b0;
        wr_cnt_hi = 1'b0;
        wr_rld_lo = 1'b0;
        wr_rld_hi = 1'b0;
        if (sfr_addr_i == ttc_pkg::CTRL_ADDR) begin
            wr_ctrl = sfr_wr_i | sfr_bit_wr_i;
        end else if (sfr_addr_i == ttc_pkg::RLD_LO_ADDR) begin
            wr_rld_lo = sfr_wr_i;
        end else if (sfr_addr_i == ttc_pkg::RLD_HI_ADDR) begin
            wr_rld_hi = sfr_wr_i;
        end else if (sfr_addr_i == ttc_pkg::CNT_LO_ADDR) begin
            wr_cnt_lo = sfr_wr_i;
        end else if (sfr_addr_i == ttc_pkg::CNT_HI_ADDR) begin
            wr_cnt_hi = sfr_wr_i;
        end
    end

    // Value a control write would leave; bit writes patch one position
    always_comb begin
        ctrl_wr_val = ctrl_r;
        if (sfr_wr_i) begin
            ctrl_wr_val = sfr_wdata_i;
        end else if (sfr_bit_wr_i) begin
            ctrl_wr_val[sfr_bit_sel_i] = sfr_bit_val_i;
        end
    end

    // Counter stepping and wrap detection
    always_comb begin
        lo_step    = 1'b0;
        hi_step    = 1'b0;
        lo_wrap    = 1'b0;
        hi_wrap    = 1'b0;
        cnt_lo_nxt = cnt_lo_r;
        cnt_hi_nxt = cnt_hi_r;
        case (mode)
            ttc_pkg::TTC_MODE_WORD: begin
                // High select is ignored here; the low byte clocks the whole word
                // Run gates word counter
                lo_step = run & lo_tick;
                lo_wrap = lo_step & (cnt_lo_r == ttc_pkg::BYTE_MAX);
                hi_wrap = lo_wrap & (cnt_hi_r == ttc_pkg::BYTE_MAX);
                hi_step = lo_wrap;
                if (hi_wrap) begin
                    cnt_lo_nxt = rld_lo_r;
                    cnt_hi_nxt = rld_hi_r;
                end else if (lo_step) begin
                    cnt_lo_nxt = cnt_lo_r + ttc_pkg::BYTE_ONE;
                    if (hi_step) begin
                        cnt_hi_nxt = cnt_hi_r + ttc_pkg::BYTE_ONE;
                    end
                end
            end
            ttc_pkg::TTC_MODE_SPLIT: begin
                lo_step = lo_tick;
                hi_step = run & hi_tick;
                lo_wrap = lo_step & (cnt_lo_r == ttc_pkg::BYTE_MAX);
                hi_wrap = hi_step & (cnt_hi_r == ttc_pkg::BYTE_MAX);
                if (lo_wrap) begin
                    cnt_lo_nxt = rld_lo_r;
                end else if (lo_step) begin
                    cnt_lo_nxt = cnt_lo_r + ttc_pkg::BYTE_ONE;
                end
                if (hi_wrap) begin
                    cnt_hi_nxt = rld_hi_r;
                end else if (hi_step) begin
                    cnt_hi_nxt = cnt_hi_r + ttc_pkg::BYTE_ONE;
                end
            end
            default: begin
                cnt_lo_nxt = cnt_lo_r;
                cnt_hi_nxt = cnt_hi_r;
            end
        endcase
    end

    // Capture happens on each oscillator fall while enabled
    // Counting goes on, so the timestamp is the count before this step
    assign cap_strobe = cap_en & slow_fall;

    // Next control byte; hardware sets beat a same-cycle software clear
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            ctrl_nxt = ctrl_wr_val & ttc_pkg::CTRL_WR_MASK;
        end
        if (hi_wrap || cap_strobe) begin
            ctrl_nxt[ttc_pkg::HF_BIT] = 1'b1;
        end
        if (lo_wrap) begin
            ctrl_nxt[ttc_pkg::LF_BIT] = 1'b1;
        end
    end

    // Control byte; flags cleared only by software writes
    // No hardware flag clear
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_r <= ttc_pkg::CTRL_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // Low count byte; a software write overrides the step that cycle
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_lo_r <= ttc_pkg::BYTE_RESET;
        end else if (wr_cnt_lo) begin
            cnt_lo_r <= sfr_wdata_i;
        end else begin
            cnt_lo_r <= cnt_lo_nxt;
        end
    end

    // High count byte
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_hi_r <= ttc_pkg::BYTE_RESET;
        end else if (wr_cnt_hi) begin
            cnt_hi_r <= sfr_wdata_i;
        end else begin
            cnt_hi_r <= cnt_hi_nxt;
        end
    end

    // Reload pair; capture wins so a timestamp is never lost
    // Copy count on capture
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rld_lo_r <= ttc_pkg::BYTE_RESET;
            rld_hi_r <= ttc_pkg::BYTE_RESET;
        end else if (cap_strobe) begin
            rld_lo_r <= cnt_lo_r;
            rld_hi_r <= cnt_hi_r;
        end else begin
            if (wr_rld_lo) begin
                rld_lo_r <= sfr_wdata_i;
            end
            if (wr_rld_hi) begin
                rld_hi_r <= sfr_wdata_i;
            end
        end
    end

    // Read data registered; unmapped addresses answer zero
    // Held until the next read, so the core may sample it late
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_r <= ttc_pkg::UNMAPPED_RD;
        end else if (sfr_rd_i) begin
            if (sfr_addr_i == ttc_pkg::CTRL_ADDR) begin
                rdata_r <= ctrl_r & ttc_pkg::CTRL_WR_MASK;
            end else if (sfr_addr_i == ttc_pkg::RLD_LO_ADDR) begin
                rdata_r <= rld_lo_r;
            end else if (sfr_addr_i == ttc_pkg::RLD_HI_ADDR) begin
                rdata_r <= rld_hi_r;
            end else if (sfr_addr_i == ttc_pkg::CNT_LO_ADDR) begin
                rdata_r <= cnt_lo_r;
            end else if (sfr_addr_i == ttc_pkg::CNT_HI_ADDR) begin
                rdata_r <= cnt_hi_r;
            end else begin
                rdata_r <= ttc_pkg::UNMAPPED_RD;
            end
        end
    end

    // Level request, held while enabled until software clears the flag
    // High flag requests
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= timer_irq_enable_i
                   & (ctrl_r[ttc_pkg::HF_BIT] | (len & ctrl_r[ttc_pkg::LF_BIT]));
        end
    end

    // Outputs straight from flops
    assign sfr_rdata_o = rdata_r;
    assign irq_o       = irq_r;

endmodule : ttc_timer2_control

// File: sim/ttc_timer2_control_checker.sv
// Purpose: Port assertions for the timer two control block
// Assumes: Bound into every control block instance
// Notes:   Count values are judged by the bench; here bus and interrupt
`timescale 1ns/1ps
module ttc_timer2_control_checker #(
    parameter int SYS_DIV = ttc_pkg::SYS_DIV,
    parameter int EXT_DIV = ttc_pkg::EXT_DIV
) (
    input wire logic       clock_i,
    input wire logic       rst_b_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic       sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic       sfr_bit_wr_i,
    input wire logic [2:0] sfr_bit_sel_i,
    input wire logic       sfr_bit_val_i,
    input wire logic       sfr_rd_i,
    input wire logic       timer_irq_enable_i,
    input wire logic       high_byte_system_clock_select_i,
    input wire logic       low_byte_system_clock_select_i,
    input wire logic       ext_osc_i,
    input wire logic       low_freq_oscillator_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic       irq_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    logic ct;
    logic ctrl_touched_r;
    assign ct = sfr_addr_i == ttc_pkg::CTRL_ADDR;
    // Until software touches control, nothing may change it
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) ctrl_touched_r <= 1'b0;
        else if ((sfr_wr_i || sfr_bit_wr_i) && ct) ctrl_touched_r <= 1'b1;
    end
    a_ctrl_reset_zero: assert property (
        sfr_rd_i && ct && !ctrl_touched_r |=> sfr_rdata_o == 8'h00)
        else $error("control not clear after reset");
    a_unused_bit_zero: assert property (
        sfr_rd_i && ct |=> !sfr_rdata_o[1]) else $error("unused bit set");
    a_ctrl_write_mask: assert property (
        sfr_wr_i && ct ##1 !sfr_wr_i && !sfr_bit_wr_i ##1 sfr_rd_i && ct
        |=> (sfr_rdata_o & 8'h3D) == ($past(sfr_wdata_i, 3) & 8'h3D))
        else $error("control write not kept");
    a_run_bit_write: assert property (
        sfr_bit_wr_i && !sfr_wr_i && ct && sfr_bit_sel_i == 3'd2
        ##1 !sfr_wr_i && !sfr_bit_wr_i ##1 sfr_rd_i && ct
        |=> sfr_rdata_o[2] == $past(sfr_bit_val_i, 3)) else $error("run bit lost");
    a_reload_write: assert property (
        sfr_wr_i && sfr_addr_i == 8'hCB ##1 !sfr_wr_i ##1 sfr_rd_i && sfr_addr_i == 8'hCB
        |=> sfr_rdata_o == $past(sfr_wdata_i, 3)) else $error("reload byte lost");
    a_irq_needs_enable: assert property (
        !timer_irq_enable_i |=> !irq_o) else $error("irq while disabled");
    a_irq_from_flags: assert property (
        sfr_rd_i && ct && timer_irq_enable_i
        |=> irq_o == (sfr_rdata_o[7] || (sfr_rdata_o[6] && sfr_rdata_o[5])))
        else $error("irq disagrees with flags");
    a_irq_held_high: assert property (
        irq_o && timer_irq_enable_i && !$past(sfr_wr_i) && !$past(sfr_bit_wr_i) |=> irq_o)
        else $error("irq dropped without a write");
endmodule : ttc_timer2_control_checker

bind ttc_timer2_control ttc_timer2_control_checker #(.SYS_DIV(SYS_DIV), .EXT_DIV(EXT_DIV)) u_chk (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_bit_wr_i(sfr_bit_wr_i), .sfr_bit_sel_i(sfr_bit_sel_i),
    .sfr_bit_val_i(sfr_bit_val_i), .sfr_rd_i(sfr_rd_i), .timer_irq_enable_i(timer_irq_enable_i),
    .high_byte_system_clock_select_i(high_byte_system_clock_select_i),
    .low_byte_system_clock_select_i(low_byte_system_clock_select_i), .ext_osc_i(ext_osc_i),
    .low_freq_oscillator_i(low_freq_oscillator_i), .sfr_rdata_o(sfr_rdata_o), .irq_o(irq_o)
);

// File: sim/ttc_core_model.sv
// Purpose: Processor core side of the register bus
// Assumes: Drives at falling edges, one request at a time
// Notes:   Released address and data show inverted values, never stale ones
`timescale 1ns/1ps
module ttc_core_model (
    input  wire logic       clock_i,
    input  wire logic [7:0] sfr_rdata_i,
    output logic [7:0]      sfr_addr_o,
    output logic            sfr_wr_o,
    output logic [7:0]      sfr_wdata_o,
    output logic            sfr_bit_wr_o,
    output logic [2:0]      sfr_bit_sel_o,
    output logic            sfr_bit_val_o,
    output logic            sfr_rd_o,
    output logic            irq_en_o,
    output logic            hsel_o,
    output logic            lsel_o
);
    // Idle bus at time zero
    initial begin
        {sfr_addr_o, sfr_wdata_o, sfr_bit_sel_o} = '0;
        {sfr_wr_o, sfr_bit_wr_o, sfr_bit_val_o, sfr_rd_o, irq_en_o, hsel_o, lsel_o} = '0;
    end
    // Byte write, one-cycle strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_i);
        {sfr_addr_o, sfr_wdata_o, sfr_wr_o} = {a, d, 1'b1};
        @(negedge clock_i);
        {sfr_addr_o, sfr_wdata_o, sfr_wr_o} = {~a, ~d, 1'b0};
    endtask : wr
    // Bit write into control byte
    task automatic bw(input logic [2:0] s, input logic v);
        @(negedge clock_i);
        {sfr_addr_o, sfr_bit_sel_o, sfr_bit_val_o, sfr_bit_wr_o} = {ttc_pkg::CTRL_ADDR, s, v, 1'b1};
        @(negedge clock_i);
        {sfr_addr_o, sfr_bit_sel_o, sfr_bit_val_o, sfr_bit_wr_o} = {~ttc_pkg::CTRL_ADDR, ~s, ~v, 1'b0};
    endtask : bw
    // Read, data settled by the next falling edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock_i);
        {sfr_addr_o, sfr_rd_o} = {a, 1'b1};
        @(negedge clock_i);
        {sfr_addr_o, sfr_rd_o} = {~a, 1'b0};
        d = sfr_rdata_i;
    endtask : rd
    // Core-held enable and clock selects
    task automatic cfg(input logic en, input logic h, input logic l);
        @(negedge clock_i);
        {irq_en_o, hsel_o, lsel_o} = {en, h, l};
    endtask : cfg
endmodule : ttc_core_model

// File: sim/ttc_timer2_control_tb.sv
// Purpose: Self-checking bench for the timer two control block
// Assumes: Core model drives the bus; bench drives both oscillators
// Notes:   Default prescaler ratios kept; the run stays short
`timescale 1ns/1ps
module ttc_timer2_control_tb;
    localparam logic [7:0] CT = ttc_pkg::CTRL_ADDR;
    localparam int TDIV = 12;
    logic       clock_i, rst_b_i, ext_osc, slow_osc, wr, bwr, bval, rd, en, hs, ls, irq;
    logic [7:0] addr, wdata, rdata, v;
    logic [2:0] bsel;
    logic [7:0] amap [6] = '{8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hC9};
    int         error_cnt, cmp_count, cyc;
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end
    ttc_core_model core (.clock_i(clock_i), .sfr_rdata_i(rdata), .sfr_addr_o(addr),
        .sfr_wr_o(wr), .sfr_wdata_o(wdata), .sfr_bit_wr_o(bwr), .sfr_bit_sel_o(bsel),
        .sfr_bit_val_o(bval), .sfr_rd_o(rd), .irq_en_o(en), .hsel_o(hs), .lsel_o(ls));
    ttc_timer2_control #(.SYS_DIV(TDIV), .EXT_DIV(8)) uut (.clock_i(clock_i),
        .rst_b_i(rst_b_i), .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_wdata_i(wdata),
        .sfr_bit_wr_i(bwr), .sfr_bit_sel_i(bsel), .sfr_bit_val_i(bval), .sfr_rd_i(rd),
        .timer_irq_enable_i(en), .high_byte_system_clock_select_i(hs),
        .low_byte_system_clock_select_i(ls), .ext_osc_i(ext_osc),
        .low_freq_oscillator_i(slow_osc), .sfr_rdata_o(rdata), .irq_o(irq));
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rc(input logic [7:0] a, input logic [7:0] e, input string n);
        core.rd(a, v);
        chk(n, e, v);
    endtask : rc
    // Request level settles within the registered lag
    task automatic irq_is(input logic e);
        repeat (3) @(negedge clock_i);
        chk("irq", {7'h0, e}, {7'h0, irq});
    endtask : irq_is
    // Word counter from a start value, run for a fixed spell
    task automatic run_from(input logic [7:0] h, input logic [7:0] l);
        core.wr(CT, 8'h00);
        core.wr(8'hCD, h);
        core.wr(8'hCC, l);
        core.wr(CT, 8'h04);
        repeat (30) @(negedge clock_i);
        core.bw(3'd2, 1'b0);
    endtask : run_from
    task automatic pulse_slow;
        repeat (5) @(negedge clock_i);
        slow_osc = 1'b1;
        repeat (5) @(negedge clock_i);
        slow_osc = 1'b0;
        repeat (6) @(negedge clock_i);
    endtask : pulse_slow
    // Hang guard, well above the expected run length
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 8000) begin
            error_cnt++;
            end_of_test();
        end
    end
    initial begin
        {rst_b_i, ext_osc, slow_osc} = 3'b000;
        {error_cnt, cmp_count, cyc} = '0;
        repeat (3) @(posedge clock_i);
        @(negedge clock_i) rst_b_i = 1'b1;
        foreach (amap[i]) rc(amap[i], 8'h00, "reset value");
        $display("test reset done");
        core.wr(CT, 8'hFF);
        rc(CT, 8'hFD, "control mask");
        core.wr(CT, 8'h00);
        rc(CT, 8'h00, "flag clear");
        $display("test control done");
        core.cfg(1'b0, 1'b1, 1'b1);
        core.wr(8'hCA, 8'h34);
        core.wr(8'hCB, 8'h12);
        rc(8'hCB, 8'h12, "reload high");
        run_from(8'h00, 8'hF0);
        rc(CT, 8'h40, "low wrap flags");
        rc(8'hCD, 8'h01, "carry");
        run_from(8'hFF, 8'hF0);
        rc(CT, 8'hC0, "full wrap flags");
        rc(8'hCD, 8'h12, "word reload");
        $display("test word done");
        core.cfg(1'b1, 1'b1, 1'b1);
        irq_is(1'b1);
        core.bw(3'd7, 1'b0);
        irq_is(1'b0);
        core.bw(3'd5, 1'b1);
        irq_is(1'b1);
        core.cfg(1'b0, 1'b1, 1'b1);
        irq_is(1'b0);
        $display("test irq done");
        core.wr(CT, 8'h08);
        core.wr(8'hCA, 8'hF0);
        core.wr(8'hCB, 8'h55);
        core.wr(8'hCD, 8'h10);
        core.wr(8'hCC, 8'hF8);
        repeat (30) @(negedge clock_i);
        rc(8'hCD, 8'h10, "high idle");
        rc(CT, 8'h48, "split flags");
        core.wr(8'hCD, 8'hFC);
        core.bw(3'd2, 1'b1);
        repeat (20) @(negedge clock_i);
        core.bw(3'd2, 1'b0);
        rc(CT, 8'hC8, "high wrap flags");
        rc(8'hCD, 8'h67, "high reload");
        $display("test split done");
        core.wr(CT, 8'h00);
        core.cfg(1'b0, 1'b1, 1'b0);
        core.wr(8'hCD, 8'h00);
        core.wr(8'hCC, 8'h00);
        core.wr(CT, 8'h04);
        repeat (TDIV * 10 - 2) @(negedge clock_i);
        core.bw(3'd2, 1'b0);
        rc(8'hCC, 8'(10), "system divider");
        core.cfg(1'b0, 1'b0, 1'b0);
        core.wr(8'hCC, 8'h00);
        core.wr(CT, 8'h0D);
        // Slow external clock, well under half the system rate
        repeat (32) begin
            repeat (3) @(negedge clock_i);
            ext_osc = 1'b1;
            repeat (3) @(negedge clock_i);
            ext_osc = 1'b0;
        end
        repeat (8) @(negedge clock_i);
        rc(8'hCC, 8'h04, "external low");
        rc(8'hCD, 8'h04, "external high");
        $display("test clocks done");
        core.wr(CT, 8'h00);
        core.cfg(1'b1, 1'b1, 1'b1);
        core.wr(8'hCB, 8'h00);
        core.wr(8'hCA, 8'h00);
        core.wr(8'hCD, 8'hA5);
        core.wr(8'hCC, 8'hC3);
        pulse_slow();
        rc(8'hCB, 8'h00, "capture off");
        core.wr(CT, 8'h10);
        pulse_slow();
        rc(8'hCB, 8'hA5, "capture high");
        rc(8'hCA, 8'hC3, "capture low");
        rc(CT, 8'h90, "capture flag");
        irq_is(1'b1);
        $display("test capture done");
        end_of_test();
    end
endmodule : ttc_timer2_control_tb
